// ---- apio_params.svh ----
`ifndef APIO_PARAMS_SVH
`define APIO_PARAMS_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define APIO_PW 22
`define APIO_CNT_W 4

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define APIO_REG_IN_LIMIT 8'h00
`define APIO_REG_IN_CURRENT 8'h04
`define APIO_REG_OUT_LIMIT 8'h08
`define APIO_REG_OUT_CURRENT 8'h0C
`define APIO_REG_CTRL 8'h10

// ------------------------------------------------------------
// Control write bits and status read bits
// ------------------------------------------------------------
`define APIO_CTL_CLR_IN 0
`define APIO_CTL_CLR_OUT 1
`define APIO_CTL_PMC 2
`define APIO_ST_IN_ACTIVE 0
`define APIO_ST_IN_INT 1
`define APIO_ST_IN_ERR 2
`define APIO_ST_IN_PFAULT 3
`define APIO_ST_IN_PEND 4
`define APIO_ST_OUT_ACTIVE 8
`define APIO_ST_OUT_INT 9
`define APIO_ST_OUT_ERR 10
`define APIO_ST_MC 16

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define APIO_CLK_NS 10
`define APIO_SAMPLE_NS 80
`define APIO_PULSE_NS 50
`define APIO_SAMPLE_CYC ((`APIO_SAMPLE_NS + `APIO_CLK_NS - 1) / `APIO_CLK_NS)
`define APIO_PULSE_CYC (`APIO_PULSE_NS / `APIO_CLK_NS)

`endif

// ---- apio_pkg.sv ----
`include "apio_params.svh"

package apio_pkg;

  typedef logic [`APIO_PW-1:0] apio_ptr_t;
  typedef logic [`APIO_CNT_W-1:0] apio_cnt_t;

  typedef enum logic [1:0] {
    IN_IDLE = 2'b00,
    IN_SAMPLE = 2'b01,
    IN_WRITE = 2'b10,
    IN_RESUME = 2'b11
  } apio_in_e;

  typedef enum logic [2:0] {
    OUT_IDLE = 3'b000,
    OUT_FETCH = 3'b001,
    OUT_READY = 3'b010,
    OUT_WAIT = 3'b011,
    OUT_DISC = 3'b100
  } apio_out_e;

  // Memory request toward the word store
  typedef struct packed {
    logic req;
    logic we;
    apio_ptr_t addr;
    logic [63:0] wdata;
  } apio_mem_s;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [19:0] din1;
    logic [19:0] din2;
    logic [31:0] rdata;
    apio_mem_s mem;
    apio_in_e ist;
    apio_ptr_t in_cur;
    apio_ptr_t in_lim;
    logic in_active;
    logic in_int;
    logic in_err;
    logic in_pfault;
    logic in_pend;
    logic in_disc;
    logic [1:0] iidx;
    apio_cnt_t icnt;
    logic [63:0] in_word;
    logic in_resume;
    apio_out_e ost;
    apio_ptr_t out_cur;
    apio_ptr_t out_lim;
    logic out_active;
    logic out_int;
    logic out_err;
    logic out_last;
    logic [1:0] oidx;
    apio_cnt_t ocnt;
    logic [63:0] out_word;
    logic [15:0] out_data;
    logic [3:0] out_par;
    logic out_ready;
    logic out_disc;
    apio_cnt_t mcnt;
    logic mc;
  } apio_state_s;

endpackage

// ---- apio_channel.sv ----
// What this block does
// - Ready while input inactive is remembered; on activation Resume, no error, no interrupt.
// - Ready during word write or at limit: error, interrupt, no Resume, data dropped.
// - Writing the current pointer sets the active flag and starts the transfer.
// - Output fetches word at current pointer, increments it, then sends parcels.
// - After fetch, pointer equal limit ends after last parcel; else fetch next.
// - Output Resume while inactive sets interrupt and error, nothing sent outward.
// - Input parcel is sampled no earlier than 80 ns after Ready edge.
// - Resume after each parcel; fourth parcel is written and pointer bumped first.
// - Disconnect after last Resume sets interrupt, deactivates; ignored at limit or inactive.
// - Four odd parity bits, one per data nibble, low nibble first.
// - Parity moves and holds exactly with the data lines.
// - Output data driven with Ready and held until that parcel's Resume.
// - At output limit, Disconnect after the last Resume, then interrupt and deactivate.
// - Output Ready, input Resume and output Disconnect are 50 ns pulses.
// - Master clear out on programmed command or general I/O clear.
// - Words move as four parcels, most significant parcel first.
// - Disconnect with partial word stores received parcels, zeros for the rest.
// - Bad parity sets fault flag at once; it sets error on Disconnect.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps

module apio_channel
  import apio_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = `APIO_SAMPLE_CYC,
  parameter int unsigned PULSE_CYC = `APIO_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Word memory port
  output apio_mem_s mem_out,
  input wire logic mem_ack_in,
  input wire logic [63:0] mem_rdata_in,
  // Input channel link
  input wire logic [15:0] in_data_in,
  input wire logic [3:0] in_par_in,
  input wire logic in_ready_in,
  input wire logic in_disc_in,
  output logic in_resume_out,
  // Output channel link
  output logic [15:0] out_data_out,
  output logic [3:0] out_par_out,
  output logic out_ready_out,
  output logic out_disc_out,
  input wire logic out_resume_in,
  // Clear and flags
  input wire logic io_clear_in,
  output logic master_clear_out,
  output logic in_int_out,
  output logic out_int_out
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (SAMPLE_CYC < 1 || SAMPLE_CYC > 15) begin : g_bad_sample
    $error("SAMPLE_CYC must lie in 1..15");
  end
  if (PULSE_CYC < 1 || PULSE_CYC > 15) begin : g_bad_pulse
    $error("PULSE_CYC must lie in 1..15");
  end

  localparam apio_cnt_t SAMPLE_N = apio_cnt_t'(SAMPLE_CYC);
  localparam apio_cnt_t PULSE_N = apio_cnt_t'(PULSE_CYC);

  apio_state_s s;
  apio_state_s next_s;

  // ------------------------------------------------------------
  // Parity and parcel selection
  // ------------------------------------------------------------
  logic [63:0] ow_src;
  logic [1:0] oi_src;
  logic [15:0] od_sel;
  logic [3:0] op_sel;
  logic [3:0] ip_bad;

  // Next outgoing parcel: parcel 0 from memory, later ones from the held word
  // high parcel first
  assign ow_src = (s.ost == OUT_FETCH) ? mem_rdata_in : s.out_word;
  assign oi_src = (s.ost == OUT_FETCH) ? 2'b00 : 2'(s.oidx + 2'b01);
  assign od_sel = ow_src[{~oi_src, 4'h0} +: 16];

  // One odd parity bit per nibble, both directions
  for (genvar g = 0; g < 4; g++) begin : g_par
    assign op_sel[g] = ~^od_sel[4*g +: 4];
    assign ip_bad[g] = s.din2[16+g] != ~^s.din2[4*g +: 4];
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic rdy_rise;
    logic dis_rise;
    logic res_rise;
    logic clr_rise;
    logic ctl_wr;
    next_s = s;
    next_s.sy1 = {in_ready_in, in_disc_in, out_resume_in, io_clear_in};
    next_s.sy2 = s.sy1;
    next_s.sy3 = s.sy2;
    next_s.din1 = {in_par_in, in_data_in};
    next_s.din2 = s.din1;
    rdy_rise = s.sy2[3] & ~s.sy3[3];
    dis_rise = s.sy2[2] & ~s.sy3[2];
    res_rise = s.sy2[1] & ~s.sy3[1];
    clr_rise = s.sy2[0] & ~s.sy3[0];
    ctl_wr = reg_wr_in && reg_addr_in == `APIO_REG_CTRL;

    // Read data stands only in the cycle after the strobe
    next_s.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `APIO_REG_IN_LIMIT: next_s.rdata = 32'(s.in_lim);
        `APIO_REG_IN_CURRENT: next_s.rdata = 32'(s.in_cur);
        `APIO_REG_OUT_LIMIT: next_s.rdata = 32'(s.out_lim);
        `APIO_REG_OUT_CURRENT: next_s.rdata = 32'(s.out_cur);
        `APIO_REG_CTRL: begin
          next_s.rdata[`APIO_ST_IN_ACTIVE] = s.in_active;
          next_s.rdata[`APIO_ST_IN_INT] = s.in_int;
          next_s.rdata[`APIO_ST_IN_ERR] = s.in_err;
          next_s.rdata[`APIO_ST_IN_PFAULT] = s.in_pfault;
          next_s.rdata[`APIO_ST_IN_PEND] = s.in_pend;
          next_s.rdata[`APIO_ST_OUT_ACTIVE] = s.out_active;
          next_s.rdata[`APIO_ST_OUT_INT] = s.out_int;
          next_s.rdata[`APIO_ST_OUT_ERR] = s.out_err;
          next_s.rdata[`APIO_ST_MC] = s.mc;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Flag clears first so that a same-cycle event below wins
    if (ctl_wr && reg_wdata_in[`APIO_CTL_CLR_IN]) begin
      next_s.in_int = 1'b0;
      next_s.in_err = 1'b0;
    end
    if (ctl_wr && reg_wdata_in[`APIO_CTL_CLR_OUT]) begin
      next_s.out_int = 1'b0;
      next_s.out_err = 1'b0;
    end

    // Pointer writes; writing current arms the channel
    if (reg_wr_in) begin
      case (reg_addr_in)
        `APIO_REG_IN_LIMIT: next_s.in_lim = reg_wdata_in[`APIO_PW-1:0];
        `APIO_REG_IN_CURRENT: begin
          next_s.in_cur = reg_wdata_in[`APIO_PW-1:0];
          next_s.in_active = 1'b1;
          next_s.in_pfault = 1'b0;
          next_s.in_disc = 1'b0;
          next_s.iidx = 2'b00;
          next_s.in_word = 64'h0;
        end
        `APIO_REG_OUT_LIMIT: next_s.out_lim = reg_wdata_in[`APIO_PW-1:0];
        `APIO_REG_OUT_CURRENT: begin
          if (s.ost == OUT_IDLE) begin
            next_s.out_cur = reg_wdata_in[`APIO_PW-1:0];
            next_s.out_active = 1'b1;
            next_s.oidx = 2'b00;
            next_s.ost = OUT_FETCH;
          end
        end
        default: ;
      endcase
    end

    // Memory answer; requests are held until acknowledged
    if (s.mem.req && mem_ack_in) begin
      next_s.mem.req = 1'b0;
      if (s.mem.we) begin
        next_s.in_cur = apio_ptr_t'(s.in_cur + 1'b1);
        next_s.in_word = 64'h0;
        next_s.iidx = 2'b00;
        if (s.in_disc) begin
          next_s.in_int = 1'b1;
          next_s.in_active = 1'b0;
          next_s.in_err = next_s.in_err | s.in_pfault;
          next_s.ist = IN_IDLE;
        end else begin
          next_s.in_resume = 1'b1;
          next_s.icnt = PULSE_N;
          next_s.ist = IN_RESUME;
        end
      end else begin
        // word back: bump pointer, send first parcel
        next_s.out_word = mem_rdata_in;
        next_s.out_cur = apio_ptr_t'(s.out_cur + 1'b1);
        next_s.out_last = apio_ptr_t'(s.out_cur + 1'b1) == s.out_lim;
        // data, parity and Ready leave together
        next_s.out_data = od_sel;
        next_s.out_par = op_sel;
        next_s.out_ready = 1'b1;
        next_s.ocnt = PULSE_N;
        next_s.ost = OUT_READY;
      end
    end

    // Input channel sequencer
    case (s.ist)
      IN_IDLE: begin
        if (s.in_active && s.in_pend) begin
          next_s.in_pend = 1'b0;
          next_s.icnt = SAMPLE_N;
          next_s.ist = IN_SAMPLE;
        end
      end
      IN_SAMPLE: begin
        next_s.icnt = apio_cnt_t'(s.icnt - 1'b1);
        if (s.icnt == 1) begin
          next_s.in_word[{~s.iidx, 4'h0} +: 16] = s.din2[15:0];
          if (ip_bad != 4'h0) begin
            next_s.in_pfault = 1'b1;
          end
          next_s.iidx = 2'(s.iidx + 2'b01);
          if (s.iidx == 2'b11) begin
            next_s.ist = IN_WRITE;
          end else begin
            next_s.in_resume = 1'b1;
            next_s.icnt = PULSE_N;
            next_s.ist = IN_RESUME;
          end
        end
      end
      IN_WRITE: begin
        if (!s.mem.req && !next_s.mem.req) begin
          next_s.mem = '{req: 1'b1, we: 1'b1, addr: s.in_cur, wdata: s.in_word};
        end
      end
      IN_RESUME: begin
        next_s.icnt = apio_cnt_t'(s.icnt - 1'b1);
        if (s.icnt == 1) begin
          next_s.in_resume = 1'b0;
          next_s.ist = IN_IDLE;
          if (s.iidx == 2'b00 && s.in_cur == s.in_lim) begin
            next_s.in_int = 1'b1;
            next_s.in_active = 1'b0;
          end
        end
      end
      default: next_s.ist = IN_IDLE;
    endcase

    // Ready events
    if (rdy_rise) begin
      if (!s.in_active) begin
        next_s.in_pend = 1'b1;
      end else if (s.ist == IN_WRITE || s.in_cur == s.in_lim) begin
        next_s.in_err = 1'b1;
        next_s.in_int = 1'b1;
        next_s.in_active = 1'b0;
      end else if (s.ist == IN_IDLE) begin
        next_s.icnt = SAMPLE_N;
        next_s.ist = IN_SAMPLE;
      end
    end

    // Disconnect honoured only when active below limit
    if (dis_rise && s.in_active && s.in_cur != s.in_lim && s.ist == IN_IDLE) begin
      if (s.iidx != 2'b00) begin
        // partial word, low parcels already zero
        next_s.in_disc = 1'b1;
        next_s.ist = IN_WRITE;
      end else begin
        next_s.in_int = 1'b1;
        next_s.in_active = 1'b0;
        next_s.in_err = next_s.in_err | s.in_pfault;
      end
    end

    // Output channel sequencer
    case (s.ost)
      OUT_IDLE: ;
      OUT_FETCH: begin
        // Input writes take the memory first
        if (!s.mem.req && !next_s.mem.req && s.ist != IN_WRITE) begin
          next_s.mem = '{req: 1'b1, we: 1'b0, addr: s.out_cur, wdata: 64'h0};
        end
      end
      OUT_READY: begin
        next_s.ocnt = apio_cnt_t'(s.ocnt - 1'b1);
        if (s.ocnt == 1) begin
          next_s.out_ready = 1'b0;
          next_s.ost = OUT_WAIT;
        end
      end
      OUT_WAIT: begin
        if (res_rise) begin
          next_s.oidx = 2'(s.oidx + 2'b01);
          if (s.oidx != 2'b11) begin
            next_s.out_data = od_sel;
            next_s.out_par = op_sel;
            next_s.out_ready = 1'b1;
            next_s.ocnt = PULSE_N;
            next_s.ost = OUT_READY;
          end else if (s.out_last) begin
            next_s.out_disc = 1'b1;
            next_s.ocnt = PULSE_N;
            next_s.ost = OUT_DISC;
          end else begin
            next_s.ost = OUT_FETCH;
          end
        end
      end
      OUT_DISC: begin
        next_s.ocnt = apio_cnt_t'(s.ocnt - 1'b1);
        if (s.ocnt == 1) begin
          next_s.out_disc = 1'b0;
          next_s.out_int = 1'b1;
          next_s.out_active = 1'b0;
          next_s.ost = OUT_IDLE;
        end
      end
      default: next_s.ost = OUT_IDLE;
    endcase

    // stray Resume on an idle output channel
    if (res_rise && !s.out_active) begin
      next_s.out_int = 1'b1;
      next_s.out_err = 1'b1;
    end

    // master clear pulse from either source
    if (clr_rise || (ctl_wr && reg_wdata_in[`APIO_CTL_PMC])) begin
      next_s.mc = 1'b1;
      next_s.mcnt = PULSE_N;
    end else if (s.mc) begin
      next_s.mcnt = apio_cnt_t'(s.mcnt - 1'b1);
      if (s.mcnt == 1) begin
        next_s.mc = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata_out = s.rdata;
  assign mem_out = s.mem;
  assign in_resume_out = s.in_resume;
  assign out_data_out = s.out_data;
  assign out_par_out = s.out_par;
  assign out_ready_out = s.out_ready;
  assign out_disc_out = s.out_disc;
  assign master_clear_out = s.mc;
  assign in_int_out = s.in_int;
  assign out_int_out = s.out_int;

endmodule // apio_channel

// ---- apio_channel_properties.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Port checks of the channel pair
// ----------------------------------------
module apio_channel_properties
  import apio_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = 8,
  parameter int unsigned PULSE_CYC = 5
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Memory and links
  input wire apio_mem_s mem_out,
  input wire logic mem_ack_in,
  input wire logic in_ready_in,
  input wire logic in_resume_out,
  input wire logic [15:0] out_data_out,
  input wire logic [3:0] out_par_out,
  input wire logic out_ready_out,
  input wire logic out_disc_out,
  input wire logic out_resume_in,
  // Clear and flags
  input wire logic io_clear_in,
  input wire logic master_clear_out,
  input wire logic in_int_out,
  input wire logic out_int_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // Cycles since the far end last held Resume high, saturating
  logic [7:0] since_res;
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) since_res <= 8'hFF;
    else if (out_resume_in) since_res <= 8'h00;
    else if (since_res != 8'hFF) since_res <= since_res + 8'h01;
  end

  a_ready_width: assert property (
    $rose(out_ready_out) |-> out_ready_out [*5] ##1 !out_ready_out)
    else $error("output ready pulse width wrong");
  a_resume_width: assert property (
    $rose(in_resume_out) |-> in_resume_out [*5] ##1 !in_resume_out)
    else $error("input resume pulse width wrong");
  a_disc_width: assert property (
    $rose(out_disc_out) |-> out_disc_out [*5] ##1 !out_disc_out)
    else $error("output disconnect pulse width wrong");
  a_out_odd_par: assert property (
    out_ready_out |-> (^{out_par_out[0], out_data_out[3:0]}) && (^{out_par_out[1],
      out_data_out[7:4]}) && (^{out_par_out[2], out_data_out[11:8]})
      && (^{out_par_out[3], out_data_out[15:12]}))
    else $error("output parity not odd");
  a_out_data_hold: assert property (
    out_ready_out && $past(out_ready_out) |-> $stable(out_data_out) && $stable(out_par_out))
    else $error("output parcel moved under ready");
  a_sample_wait: assert property (
    $rose(in_ready_in) |=> !in_resume_out [*8])
    else $error("input resume before sampling time");
  a_mclr_io: assert property (
    $rose(io_clear_in) |-> ##[1:6] master_clear_out)
    else $error("no master clear after io clear");
  a_disc_after_res: assert property (
    $rose(out_disc_out) |-> since_res < 8'h0C)
    else $error("disconnect not after a resume");
  a_int_after_disc: assert property (
    $fell(out_disc_out) |-> ##[0:3] out_int_out)
    else $error("no output interrupt after disconnect");
  a_mem_req_hold: assert property (
    mem_out.req && !mem_ack_in |=> mem_out.req && $stable(mem_out.addr))
    else $error("memory request dropped before ack");

  // Main scenarios reached
  cover property ($rose(out_disc_out));
  cover property ($rose(in_int_out));
  cover property ($rose(master_clear_out));
endmodule // apio_channel_properties

bind apio_channel apio_channel_properties #(.SAMPLE_CYC(SAMPLE_CYC), .PULSE_CYC(PULSE_CYC))
  i_apio_channel_properties (.mclk_in, .resetn_in, .mem_out, .mem_ack_in, .in_ready_in,
  .in_resume_out, .out_data_out, .out_par_out, .out_ready_out, .out_disc_out,
  .out_resume_in, .io_clear_in, .master_clear_out, .in_int_out, .out_int_out);

// ---- apio_far_end.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Far end device on the cable
// ----------------------------------------
module apio_far_end
  import apio_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Input channel side
  input wire logic in_resume_in,
  output logic [15:0] in_data_out,
  output logic [3:0] in_par_out,
  output logic in_ready_out,
  output logic in_disc_out,
  // Output channel side
  input wire logic [15:0] out_data_in,
  input wire logic [3:0] out_par_in,
  input wire logic out_ready_in,
  input wire logic out_disc_in,
  output logic out_resume_out
);
  int gap = 6;
  int n_resume = 0;
  int n_disc = 0;
  logic [19:0] rx_q[$];

  function automatic logic [3:0] odd_par(input logic [15:0] d);
    for (int g = 0; g < 4; g++) odd_par[g] = ~^d[4*g +: 4];
  endfunction

  // parcel with Ready, held until its Resume
  task automatic send_parcel(input logic [15:0] d, input logic bad);
    int i;
    @(posedge mclk_in);
    in_data_out <= d;
    in_par_out <= odd_par(d) ^ {3'h0, bad};
    in_ready_out <= 1'b1;
    repeat (5) @(posedge mclk_in);
    in_ready_out <= 1'b0;
    for (i = 0; i < 400 && in_resume_in !== 1'b1; i++) @(posedge mclk_in);
    if (in_resume_in === 1'b1) n_resume++;
    for (i = 0; i < 20 && in_resume_in !== 1'b0; i++) @(posedge mclk_in);
    // Released lines show the inverse so stale data never looks valid
    in_data_out <= ~d;
    in_par_out <= ~in_par_out;
  endtask

  task automatic send_disc();
    @(posedge mclk_in);
    in_disc_out <= 1'b1;
    repeat (5) @(posedge mclk_in);
    in_disc_out <= 1'b0;
  endtask

  // Stray Resume, only when a scenario asks for it
  task automatic stray_resume();
    @(posedge mclk_in);
    out_resume_out <= 1'b1;
    repeat (5) @(posedge mclk_in);
    out_resume_out <= 1'b0;
  endtask

  // Ready with no parcel behind it, for the unexpected Ready scenario
  task automatic extra_ready();
    @(posedge mclk_in);
    in_ready_out <= 1'b1;
    repeat (5) @(posedge mclk_in);
    in_ready_out <= 1'b0;
  endtask

  // take each output parcel, answer after gap cycles
  initial begin
    in_data_out = 16'h0000;
    in_par_out = 4'hF;
    in_ready_out = 1'b0;
    in_disc_out = 1'b0;
    out_resume_out = 1'b0;
    forever begin
      // Level wait: the next Ready rises while our Resume is still high
      wait (out_ready_in === 1'b1);
      @(negedge mclk_in);
      rx_q.push_back({out_par_in, out_data_in});
      repeat (gap) @(posedge mclk_in);
      out_resume_out <= 1'b1;
      repeat (5) @(posedge mclk_in);
      out_resume_out <= 1'b0;
    end
  end

  // Count disconnects seen
  always @(posedge out_disc_in) n_disc++;
endmodule // apio_far_end

// ---- apio_channel_tb.sv ----
`timescale 1ns/1ps

module apio_channel_tb
  import apio_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0, io_clr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic [63:0] mrdata = 64'h0;
  apio_mem_s mo;
  logic [15:0] i_d, o_d;
  logic [3:0] i_p, o_p;
  logic i_rdy, i_dsc, i_res, o_rdy, o_dsc, o_res, mclr, iint, oint;
  logic [63:0] mem [0:15];
  int n_fail = 0, comparisons = 0, mwait = 0, mlat = 2;

  always #5 mclk = ~mclk;

  apio_channel i_apio_channel (.mclk_in(mclk), .resetn_in(resetn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .mem_out(mo), .mem_ack_in(ack), .mem_rdata_in(mrdata), .in_data_in(i_d),
    .in_par_in(i_p), .in_ready_in(i_rdy), .in_disc_in(i_dsc), .in_resume_out(i_res),
    .out_data_out(o_d), .out_par_out(o_p), .out_ready_out(o_rdy), .out_disc_out(o_dsc),
    .out_resume_in(o_res), .io_clear_in(io_clr), .master_clear_out(mclr),
    .in_int_out(iint), .out_int_out(oint));

  apio_far_end i_apio_far_end (.mclk_in(mclk), .in_resume_in(i_res), .in_data_out(i_d),
    .in_par_out(i_p), .in_ready_out(i_rdy), .in_disc_out(i_dsc), .out_data_in(o_d),
    .out_par_in(o_p), .out_ready_in(o_rdy), .out_disc_in(o_dsc), .out_resume_out(o_res));

  // Word store: acknowledge after mlat wait cycles of a request
  always @(posedge mclk) begin
    ack <= 1'b0;
    if (mo.req && !ack) begin
      if (mwait == mlat) begin
        ack <= 1'b1;
        mwait <= 0;
        mrdata <= mem[mo.addr[3:0]];
        if (mo.we) mem[mo.addr[3:0]] <= mo.wdata;
      end else mwait <= mwait + 1;
    end
  end

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 st = rdata;
  endtask

  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 600 && s !== 1'b1; i++) @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_output(input int base, input int n, input int gap);
    int d0;
    logic [19:0] p;
    d0 = i_apio_far_end.n_disc;
    i_apio_far_end.gap = gap;
    i_apio_far_end.rx_q.delete();
    reg_wr(8'h10, 32'h2);
    reg_wr(8'h08, 32'(base + n));
    reg_wr(8'h0C, 32'(base));
    wait_hi(oint);
    check(64'(i_apio_far_end.rx_q.size()), 64'(4 * n));
    for (int k = 0; k < 4 * n; k++) begin
      p = i_apio_far_end.rx_q[k];
      check(64'(p[15:0]), 64'(mem[base + k / 4][63 - 16 * (k % 4) -: 16]));
      check(64'(p[19:16]), 64'(i_apio_far_end.odd_par(p[15:0])));
    end
    reg_rd(8'h0C);
    check(64'(st), 64'(base + n));
    reg_rd(8'h10);
    check(64'(st[10:8]), 64'h2);
    check(64'(i_apio_far_end.n_disc - d0), 64'h1);
  endtask

  task automatic t_out_stray();
    int k;
    k = i_apio_far_end.rx_q.size();
    reg_wr(8'h10, 32'h2);
    i_apio_far_end.stray_resume();
    repeat (10) @(posedge mclk);
    reg_rd(8'h10);
    check(64'(st[10:8]), 64'h6);
    check(64'(i_apio_far_end.rx_q.size()), 64'(k));
  endtask

  task automatic t_in_pending();
    fork
      i_apio_far_end.send_parcel(16'hA5C3, 1'b0);
      begin
        repeat (30) @(posedge mclk);
        reg_rd(8'h10);
        check(64'(st[4]), 64'h1);
        reg_wr(8'h00, 32'h9);
        reg_wr(8'h04, 32'h8);
      end
    join
    i_apio_far_end.send_parcel(16'h3C5A, 1'b0);
    i_apio_far_end.send_parcel(16'h0000, 1'b0);
    i_apio_far_end.send_parcel(16'hFFFF, 1'b0);
    wait_hi(iint);
    check(mem[8], 64'hA5C3_3C5A_0000_FFFF);
    check(64'(i_apio_far_end.n_resume), 64'h4);
    reg_rd(8'h10);
    check(64'(st[2:0]), 64'h2);
    reg_rd(8'h04);
    check(64'(st), 64'h9);
  endtask

  task automatic t_in_partial();
    reg_wr(8'h10, 32'h1);
    reg_wr(8'h00, 32'hC);
    reg_wr(8'h04, 32'hA);
    i_apio_far_end.send_parcel(16'h1111, 1'b0);
    i_apio_far_end.send_parcel(16'h2222, 1'b1);
    reg_rd(8'h10);
    check(64'(st[3:1]), 64'h4);
    i_apio_far_end.send_disc();
    wait_hi(iint);
    check(mem[10], 64'h1111_2222_0000_0000);
    reg_rd(8'h10);
    check(64'(st[2:0]), 64'h6);
    reg_rd(8'h04);
    check(64'(st), 64'hB);
    reg_wr(8'h10, 32'h1);
    i_apio_far_end.send_disc();
    repeat (10) @(posedge mclk);
    check(64'(iint), 64'h0);
  endtask

  // Extra Ready while the fourth parcel waits on a slow memory write
  task automatic t_in_busy();
    reg_wr(8'h10, 32'h1);
    reg_wr(8'h00, 32'hF);
    reg_wr(8'h04, 32'hD);
    i_apio_far_end.send_parcel(16'h0123, 1'b0);
    i_apio_far_end.send_parcel(16'h4567, 1'b0);
    i_apio_far_end.send_parcel(16'h89AB, 1'b0);
    mlat = 30;
    fork
      i_apio_far_end.send_parcel(16'hCDEF, 1'b0);
      begin
        repeat (15) @(posedge mclk);
        i_apio_far_end.extra_ready();
      end
    join
    mlat = 2;
    reg_rd(8'h10);
    check(64'(st[2:0]), 64'h6);
    check(mem[13], 64'h0123_4567_89AB_CDEF);
  endtask

  task automatic t_mclr();
    int n;
    reg_wr(8'h10, 32'h4);
    wait_hi(mclr);
    // wait_hi first looks after the first high cycle has passed, so n starts at 1
    for (n = 1; n < 20 && mclr === 1'b1; n++) @(posedge mclk) #1;
    check(64'(n), 64'h5);
    @(posedge mclk);
    io_clr <= 1'b1;
    wait_hi(mclr);
    check(64'(mclr), 64'h1);
    @(posedge mclk);
    io_clr <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    mem[4] = 64'h1234_5678_9ABC_DEF0;
    mem[5] = 64'h0F1E_2D3C_4B5A_6978;
    mem[7] = 64'hFFFF_0000_8001_7FFE;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    reg_rd(8'h10);
    check(64'(st), 64'h0);
    reg_rd(8'h14);
    check(64'(st), 64'h0);
    t_output(4, 2, 25);
    t_output(7, 1, 6);
    t_out_stray();
    t_in_pending();
    t_in_partial();
    t_in_busy();
    t_mclr();
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule // apio_channel_tb
